// ### logic/lic_pkg.sv
// Constants shared by the legacy interrupt compatibility block
package lic_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_DIST_CTRL = 12'h000;
  localparam logic [11:0] OFS_DIST_TYPE = 12'h004;
  localparam logic [11:0] OFS_CONTEXT = 12'h008;
  localparam logic [11:0] OFS_CPU_CTRL = 12'h00C;
  localparam logic [11:0] OFS_TOP_CTRL = 12'h010;
  localparam logic [11:0] OFS_VIRT_CTRL = 12'h014;
  localparam logic [11:0] OFS_LEG_SGI_GEN = 12'h020;
  localparam logic [11:0] OFS_SGI_GROUP = 12'h024;
  localparam logic [11:0] OFS_SGI_GRPMOD = 12'h028;
  localparam logic [11:0] OFS_EN_SET = 12'h02C;
  localparam logic [11:0] OFS_EN_CLR = 12'h030;
  localparam logic [11:0] OFS_SYS_SGI_GEN = 12'h034;
  localparam logic [11:0] OFS_PHYS_ACK = 12'h040;
  localparam logic [11:0] OFS_PHYS_HPP = 12'h044;
  localparam logic [11:0] OFS_PHYS_AACK = 12'h048;
  localparam logic [11:0] OFS_PHYS_AHPP = 12'h04C;
  localparam logic [11:0] OFS_VIRT_ACK = 12'h050;
  localparam logic [11:0] OFS_VIRT_HPP = 12'h054;
  localparam logic [11:0] OFS_VIRT_AACK = 12'h058;
  localparam logic [11:0] OFS_VIRT_AHPP = 12'h05C;
  localparam logic [11:0] OFS_G0_ACK = 12'h060;
  localparam logic [11:0] OFS_EOI = 12'h064;
  localparam logic [11:0] OFS_PEND_SRC_SET = 12'h070;
  localparam logic [11:0] OFS_PEND_SRC_CLR = 12'h074;
  localparam logic [11:0] OFS_REDIST_SET = 12'h080;
  localparam logic [11:0] OFS_REDIST_CLR = 12'h084;
  localparam logic [11:0] OFS_IRQ_TARGETS = 12'h090;
  localparam logic [11:0] OFS_REDIST_TYPE = 12'h094;
  localparam logic [11:0] OFS_CFG_STATUS = 12'h098;
  // Field positions
  localparam int B_EN_G0 = 0;
  localparam int B_EN_G1 = 1;
  localparam int B_ACK_CONTROL = 2;
  localparam int B_FAST_IRQ_ENABLE = 3;
  localparam int B_ARE_S = 4;
  localparam int B_AFFINITY_ROUTE_EN_NONSECURE = 5;
  localparam int B_SECDIS = 6;
  localparam int B_NS = 4;
  localparam int B_PMASK_LSB = 8;
  localparam int B_FILT_LSB = 24;
  localparam int B_TLIST_LSB = 16;
  localparam int B_KIND_LSB = 20;
  localparam int B_SYS_ID_LSB = 24;
  // Special identifiers
  localparam logic [9:0] ID_RM_G0 = 10'h3FC;
  localparam logic [9:0] ID_RM_G1NS = 10'h3FD;
  localparam logic [9:0] ID_LEG_G1 = 10'h3FE;
  localparam logic [9:0] ID_NONE = 10'h3FF;
  // Target filter and generator kinds
  localparam logic [1:0] FILT_LIST = 2'h0;
  localparam logic [1:0] FILT_OTHERS = 2'h1;
  localparam logic [1:0] FILT_SELF = 2'h2;
  localparam logic [1:0] KIND_G0 = 2'h0;
  localparam logic [1:0] KIND_G1 = 2'h1;
  localparam logic [1:0] KIND_ALT = 2'h2;
  // Legacy configuration codes
  localparam logic [1:0] CFG_NONE = 2'h0;
  localparam logic [1:0] CFG_SINGLE = 2'h1;
  localparam logic [1:0] CFG_TWO = 2'h2;
  localparam logic [1:0] CFG_ASYM = 2'h3;
endpackage

// ### logic/lic_sgi_mem.sv
// Banked software interrupt pending store, one row per processing element
`timescale 1ns/1ns
`default_nettype none
module lic_sgi_mem #(
  parameter int NPE = 16,
  parameter int NSGI = 16,
  parameter int PW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NPE-1:0] set_rows,
  input wire logic [NSGI-1:0] set_bits,
  input wire logic clr_en,
  input wire logic [PW-1:0] clr_row,
  input wire logic [NSGI-1:0] clr_bits,
  input wire logic [PW-1:0] rd_row,
  output logic [NSGI-1:0] rd_data_q
);
  logic [NSGI-1:0] mem_q [NPE];

  ////////////////////////////////////////////////////////////////////////////
  // Rows update; a set in the same cycle beats a clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NPE; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < NPE; i++)
      begin
        if (clr_en && (clr_row == PW'(i)))
          mem_q[i] <= (mem_q[i] & ~clr_bits) |
                      (set_rows[i] ? set_bits : '0);
        else if (set_rows[i])
          mem_q[i] <= mem_q[i] | set_bits;
      end
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_q <= '0;
    else
      rd_data_q <= mem_q[rd_row];
  end
endmodule // lic_sgi_mem
`default_nettype wire

// ### logic/lic_sgi_pick.sv
// Highest priority pending software interrupt selector
`timescale 1ns/1ns
`default_nettype none
module lic_sgi_pick #(
  parameter int NSGI = 16,
  parameter int IW = 4
) (
  input wire logic [NSGI-1:0] pend,
  input wire logic [NSGI-1:0] enable,
  input wire logic [NSGI-1:0] is_g0,
  input wire logic act_g0,
  input wire logic act_g1,
  input wire logic [IW:0] prio_mask,
  output logic found,
  output logic sufficient,
  output logic [IW-1:0] top_id,
  output logic top_g0
);
  logic [NSGI-1:0] elig;

  ////////////////////////////////////////////////////////////////////////////
  // Disabled groups drop out before priority, lower index wins
  always_comb
  begin
    elig = pend & enable & ((is_g0 & {NSGI{act_g0}}) |
                            (~is_g0 & {NSGI{act_g1}}));
    found = 1'b0;
    top_id = '0;
    for (int i = NSGI - 1; i >= 0; i--)
    begin
      if (elig[i])
      begin
        found = 1'b1;
        top_id = IW'(i);
      end
    end
    top_g0 = is_g0[top_id];
    sufficient = found && ({1'b0, top_id} < prio_mask);
  end
endmodule // lic_sgi_pick
`default_nettype wire

// ### logic/lic_compat.sv
// Legacy and asymmetric compatibility logic with an AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module lic_compat
  import lic_pkg::*;
#(
  parameter int NPE = 16,
  parameter int NSGI = 16,
  parameter bit LEGACY_SUPPORT = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import lic_pkg::*;

  localparam int PW = $clog2(NPE);
  localparam int IW = $clog2(NSGI);

  // Bus state
  logic ph_q;
  logic wr_q;
  logic [11:0] adr_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic hresp_q;
  // Control state
  logic en_g0_q, en_g1_q, are_s_q, affinity_route_en_nonsecure_q, ds_q;
  logic [PW-1:0] pe_q;
  logic ns_q;
  logic cpu_g0_q, cpu_g1_q, fiq_en_q;
  logic [IW:0] pmask_q;
  logic rm_q;
  logic [2:0] sre_q;
  logic vack_q;
  logic [NSGI-1:0] grp_q, gmod_q, sgi_en_q;
  logic [7:0] tgt_q;
  logic [NSGI-1:0] active_q [NPE];
  // Datapath
  logic are_s, affinity_route_en_nonsecure, are_cur;
  logic [2:0] sre_rd;
  logic [NSGI-1:0] pend, g0_mask;
  logic found, suff, top_g0;
  logic [IW-1:0] top_id;
  logic [NPE-1:0] set_rows;
  logic [NSGI-1:0] set_bits, clr_bits;
  logic clr_en, do_wr, do_rd, ack_do;
  logic [9:0] ack_id;
  logic [31:0] rd_d;
  logic [1:0] cfg;
  logic [IW-1:0] wid;
  logic [1:0] filt;

  ////////////////////////////////////////////////////////////////////////////
  // Affinity routing in force for an access of a given security state
  function automatic logic are_for(input logic ns, input logic ds,
                                   input logic a_s, input logic a_ns);
    are_for = (ns || ds) ? a_ns : a_s;
  endfunction

  // Delivery mask from a list of element numbers
  function automatic logic [NPE-1:0] rows_of(input logic [15:0] list);
    for (int i = 0; i < NPE; i++)
      rows_of[i] = (i < 16) ? list[i] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-one bits when legacy support is absent
  assign are_s = LEGACY_SUPPORT ? are_s_q : 1'b1;
  assign affinity_route_en_nonsecure = LEGACY_SUPPORT ? affinity_route_en_nonsecure_q : 1'b1;
  assign sre_rd = LEGACY_SUPPORT ? sre_q : 3'h7;
  assign are_cur = are_for(ns_q, ds_q, are_s, affinity_route_en_nonsecure);
  assign do_wr = ph_q && wr_q;
  assign do_rd = ph_q && !wr_q;
  assign wid = hwdata[IW-1:0];
  assign filt = hwdata[B_FILT_LSB +: 2];

  // Secure Group 1 folds into Group 0 while secure side is legacy
  assign g0_mask = are_s ? (~grp_q & ~gmod_q) : ~grp_q;

  // Pending rows, banked by target element only
  lic_sgi_mem #(.NPE(NPE), .NSGI(NSGI), .PW(PW)) u_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .set_rows(set_rows),
    .set_bits(set_bits),
    .clr_en(clr_en),
    .clr_row(pe_q),
    .clr_bits(clr_bits),
    .rd_row(pe_q),
    .rd_data_q(pend)
  );

  // Active interrupts are not offered again until ended
  lic_sgi_pick #(.NSGI(NSGI), .IW(IW)) u_pick (
    .pend(pend & ~active_q[pe_q]),
    .enable(sgi_en_q),
    .is_g0(g0_mask),
    .act_g0(en_g0_q),
    .act_g1(en_g1_q),
    .prio_mask(pmask_q),
    .found(found),
    .sufficient(suff),
    .top_id(top_id),
    .top_g0(top_g0)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Legacy configuration detection
  always_comb
  begin
    if (ds_q && !affinity_route_en_nonsecure && sre_rd == 3'h0)
      cfg = CFG_SINGLE;
    else if (!ds_q && !affinity_route_en_nonsecure && !are_s && sre_rd == 3'h0)
      cfg = CFG_TWO;
    else if (!ds_q && affinity_route_en_nonsecure && !are_s && !sre_rd[0])
      cfg = CFG_ASYM;
    else
      cfg = CFG_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending sets from the legacy and system-register generators and the set-pending registers
  always_comb
  begin
    set_rows = '0;
    set_bits = '0;
    if (do_wr && adr_q == OFS_LEG_SGI_GEN && !are_cur &&
        {{(32-PW){1'b0}}, pe_q} <= 32'd7 &&
        !(ns_q && !ds_q && !grp_q[wid]))
    begin
      set_bits[wid] = 1'b1;
      case (filt)
        FILT_LIST: set_rows = rows_of({8'h00,
                               hwdata[B_TLIST_LSB +: 8]});
        FILT_OTHERS:
        begin
          set_rows = '1;
          set_rows[pe_q] = 1'b0;
        end
        FILT_SELF: set_rows[pe_q] = 1'b1;
        default: set_rows = '0;
      endcase
    end
    else if (do_wr && adr_q == OFS_SYS_SGI_GEN)
    begin
      set_bits[hwdata[B_SYS_ID_LSB +: IW]] = 1'b1;
      case (hwdata[B_KIND_LSB +: 2])
        KIND_G0, KIND_ALT:
        begin
          if (ds_q)
            set_rows = rows_of(hwdata[15:0]);
          else if (!ns_q && hwdata[B_KIND_LSB +: 2] == KIND_G0)
            set_rows = rows_of(hwdata[15:0]);
          else if (are_s && affinity_route_en_nonsecure)
            set_rows = rows_of(hwdata[15:0]);
        end
        KIND_G1: set_rows = rows_of(hwdata[15:0]);
        default: set_rows = '0;
      endcase
    end
    else if (do_wr && adr_q == OFS_REDIST_SET)
    begin
      set_rows[pe_q] = 1'b1;
      set_bits = hwdata[NSGI-1:0];
    end
    else if (do_wr && adr_q == OFS_PEND_SRC_SET && !are_cur)
    begin
      set_rows[pe_q] = 1'b1;
      set_bits = hwdata[NSGI-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge decisions and register read mux
  always_comb
  begin
    ack_do = 1'b0;
    ack_id = ID_NONE;
    rd_d = 32'h0000_0000;
    case (adr_q)
      OFS_DIST_CTRL: rd_d = {25'h0, ds_q, affinity_route_en_nonsecure, are_s, 2'h0,
                             en_g1_q, en_g0_q};
      OFS_DIST_TYPE: rd_d = 32'(NPE - 1);
      OFS_CONTEXT: rd_d = {27'h0, ns_q, 4'(pe_q)};
      OFS_CPU_CTRL: rd_d = (32'(pmask_q) << B_PMASK_LSB) |
                           {28'h0, fiq_en_q, 1'b0,
                            cpu_g1_q, cpu_g0_q};
      OFS_TOP_CTRL: rd_d = {28'h0, sre_rd, rm_q};
      OFS_VIRT_CTRL: rd_d = {31'h0, vack_q};
      OFS_SGI_GROUP: rd_d = 32'(grp_q);
      OFS_SGI_GRPMOD: rd_d = 32'(gmod_q);
      OFS_EN_SET, OFS_EN_CLR: rd_d = 32'(sgi_en_q);
      OFS_PEND_SRC_SET, OFS_PEND_SRC_CLR:
        rd_d = are_cur ? 32'h0 : 32'(pend);
      OFS_REDIST_SET, OFS_REDIST_CLR: rd_d = 32'(pend);
      OFS_IRQ_TARGETS: rd_d = are_cur ? 32'h0 : 32'(tgt_q);
      OFS_REDIST_TYPE: rd_d = 32'(pe_q);
      OFS_CFG_STATUS: rd_d = {30'h0, cfg};
      OFS_PHYS_ACK, OFS_PHYS_HPP:
      begin
        if (suff && (ns_q ? !top_g0 : top_g0))
        begin
          ack_id = 10'(top_id);
          ack_do = (adr_q == OFS_PHYS_ACK);
        end
        else if (suff && !ns_q && !are_s)
          ack_id = ID_LEG_G1;
      end
      OFS_PHYS_AACK, OFS_PHYS_AHPP, OFS_VIRT_AACK, OFS_VIRT_AHPP:
      begin
        if (suff && !top_g0)
        begin
          ack_id = 10'(top_id);
          ack_do = (adr_q == OFS_PHYS_AACK) || (adr_q == OFS_VIRT_AACK);
        end
      end
      OFS_VIRT_ACK, OFS_VIRT_HPP:
      begin
        // Only the requesting element's own interrupts are visible
        if (suff && !top_g0 && !vack_q)
          ack_id = ID_LEG_G1;
        else if (suff)
        begin
          ack_id = 10'(top_id);
          ack_do = (adr_q == OFS_VIRT_ACK);
        end
      end
      OFS_G0_ACK:
      begin
        if (suff && rm_q)
          ack_id = top_g0 ? ID_RM_G0 : ID_RM_G1NS;
        else if (suff && top_g0)
        begin
          ack_id = 10'(top_id);
          ack_do = 1'b1;
        end
      end
      default: rd_d = 32'h0000_0000;
    endcase
    if (ack_id != ID_NONE || adr_q inside {OFS_PHYS_ACK, OFS_PHYS_HPP,
        OFS_PHYS_AACK, OFS_PHYS_AHPP, OFS_VIRT_ACK, OFS_VIRT_HPP,
        OFS_VIRT_AACK, OFS_VIRT_AHPP, OFS_G0_ACK})
      rd_d = {22'h0, ack_id};
    ack_do = ack_do && do_rd;
  end

  // Pending clears from acknowledges and clear registers
  always_comb
  begin
    clr_en = 1'b0;
    clr_bits = '0;
    if (ack_do)
    begin
      clr_en = 1'b1;
      clr_bits[top_id] = 1'b1;
    end
    else if (do_wr && (adr_q == OFS_REDIST_CLR ||
             (adr_q == OFS_PEND_SRC_CLR && !are_cur)))
    begin
      clr_en = 1'b1;
      clr_bits = hwdata[NSGI-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state, then the answer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 12'h000;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else if (ph_q)
    begin
      ph_q <= 1'b0;
      hready_q <= 1'b1;
      if (!wr_q)
        hrdata_q <= rd_d;
    end
    else if (hsel && hready && htrans[1])
    begin
      ph_q <= 1'b1;
      wr_q <= hwrite;
      adr_q <= {haddr[11:2], 2'b00};
      hready_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Distributor, context and interface control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {en_g0_q, en_g1_q, are_s_q, affinity_route_en_nonsecure_q, ds_q} <= 5'h00;
      pe_q <= '0;
      ns_q <= 1'b0;
      {cpu_g0_q, cpu_g1_q, fiq_en_q} <= 3'h0;
      pmask_q <= '1;
      rm_q <= 1'b0;
      sre_q <= 3'h0;
      vack_q <= 1'b0;
      tgt_q <= 8'h00;
    end
    else if (do_wr)
    begin
      case (adr_q)
        OFS_DIST_CTRL:
        begin
          en_g0_q <= hwdata[B_EN_G0];
          en_g1_q <= hwdata[B_EN_G1];
          are_s_q <= hwdata[B_ARE_S];
          affinity_route_en_nonsecure_q <= hwdata[B_AFFINITY_ROUTE_EN_NONSECURE];
          ds_q <= hwdata[B_SECDIS];
        end
        OFS_CONTEXT:
        begin
          pe_q <= hwdata[PW-1:0];
          ns_q <= hwdata[B_NS];
        end
        OFS_CPU_CTRL:
        begin
          cpu_g0_q <= hwdata[B_EN_G0];
          cpu_g1_q <= hwdata[B_EN_G1];
          fiq_en_q <= hwdata[B_FAST_IRQ_ENABLE];
          pmask_q <= hwdata[B_PMASK_LSB +: IW+1];
        end
        OFS_TOP_CTRL:
        begin
          rm_q <= hwdata[0];
          sre_q <= hwdata[3:1];
        end
        OFS_VIRT_CTRL: vack_q <= hwdata[0];
        OFS_IRQ_TARGETS: if (!are_cur) tgt_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Group and enable configuration; enables reset cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      grp_q <= '0;
      gmod_q <= '0;
      sgi_en_q <= '0;
    end
    else if (do_wr)
    begin
      if (adr_q == OFS_SGI_GROUP)
        grp_q <= hwdata[NSGI-1:0];
      if (adr_q == OFS_SGI_GRPMOD)
        gmod_q <= hwdata[NSGI-1:0];
      if (adr_q == OFS_EN_SET)
        sgi_en_q <= sgi_en_q | hwdata[NSGI-1:0];
      if (adr_q == OFS_EN_CLR)
        sgi_en_q <= sgi_en_q & ~hwdata[NSGI-1:0];
    end
  end

  // Active state per element; acknowledge sets, end-of-interrupt clears
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NPE; i++)
        active_q[i] <= '0;
    end
    else if (ack_do)
      active_q[pe_q][top_id] <= 1'b1;
    else if (do_wr && adr_q == OFS_EOI)
      active_q[pe_q][wid] <= 1'b0;
  end
endmodule // lic_compat
`default_nettype wire

// ### tb/lic_compat_assertions.sv
// Checker for bus timing and fixed register fields of the compatibility block
`timescale 1ns/1ns
`default_nettype none
module lic_compat_chk
  import lic_pkg::*;
#(
  parameter int NPE = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  logic take;
  logic rl;
  logic ph_q;
  logic w_q;
  logic dn_q;
  logic [11:0] a_q;
  assign take = hsel & hready & htrans[1];
  assign rl = ph_q & ~w_q;
  // Follow the transfer in flight and flag the cycle its read data stands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_q <= 1'b0;
      dn_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= 12'h000;
    end
    else
    begin
      ph_q <= take;
      dn_q <= rl;
      if (take)
      begin
        w_q <= hwrite;
        a_q <= haddr[11:0];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  a_wait_one: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("transfer wait state not exactly one cycle");
  a_idle_ready: assert property (!ph_q |-> hreadyout)
    else $error("ready low with no transfer");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (!$past(rl) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_ack_control_zero: assert property (
    dn_q && a_q == OFS_CPU_CTRL |-> !hrdata[B_ACK_CONTROL])
    else $error("ack control bit reads one");
  a_lock_zero: assert property (
    dn_q && a_q == OFS_DIST_TYPE |-> hrdata == 32'(NPE - 1))
    else $error("type register field wrong");
  a_ack_nosrc: assert property (
    dn_q && a_q >= OFS_PHYS_ACK && a_q <= OFS_G0_ACK
    |-> hrdata[31:10] == 22'h0)
    else $error("acknowledge carries extra bits");
  a_alias_plain: assert property (
    dn_q && (a_q == OFS_PHYS_AACK || a_q == OFS_G0_ACK)
    |-> hrdata[9:0] != ID_LEG_G1)
    else $error("alias or top ack returned legacy group one id");
  a_cfg_code: assert property (
    dn_q && a_q == OFS_CFG_STATUS |-> hrdata[31:2] == 30'h0)
    else $error("configuration code out of range");
  c_write: cover property (take && hwrite);
  c_leg_id: cover property (dn_q && a_q == OFS_PHYS_HPP &&
    hrdata[9:0] == ID_LEG_G1);
  c_rm_id: cover property (dn_q && a_q == OFS_G0_ACK &&
    hrdata[9:0] == ID_RM_G0);
endmodule // lic_compat_chk
bind lic_compat lic_compat_chk #(.NPE(NPE)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// ### tb/lic_sw_model.sv
// Software side model: a single-word bus master
`timescale 1ns/1ns
`default_nettype none
module lic_sw_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One transfer; called right after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic tmo);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    // Released lines show a changing pattern, not the old value
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= wr ? d : ~hwdata;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    r = hrdata;
    tmo = (n >= 100);
  endtask
endmodule // lic_sw_model
`default_nettype wire

// ### tb/lic_compat_bench.sv
// Register-level bench for the compatibility block
`timescale 1ns/1ns
`default_nettype none
module lic_compat_bench;
  import lic_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int n_errors = 0;
  int total_checks = 0;
  lic_compat uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  lic_sw_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  always #10 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    logic t;
    m.xfer(w, a, d, r, t);
    if (t)
    begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    go(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    go(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // Read the pending row of one element; leaves that element as context
  task automatic pend(input logic [4:0] c, input logic [31:0] e);
    wr(OFS_CONTEXT, {27'h0, c});
    rc(OFS_REDIST_SET, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and fixed fields
    rc(OFS_DIST_CTRL, 32'h0);
    rc(OFS_DIST_TYPE, 32'h0000_000F);
    rc(OFS_EN_SET, 32'h0);
    rc(OFS_CFG_STATUS, {30'h0, CFG_TWO});
    rc(OFS_CPU_CTRL, 32'h0000_1F00);
    wr(OFS_CPU_CTRL, 32'h0000_1F0F);
    rc(OFS_CPU_CTRL, 32'h0000_1F0B);
    wr(12'hFFC, 32'hFFFF_FFFF);
    rc(12'hFFC, 32'h0);
    wr(OFS_EN_SET, 32'h0000_FFFF);
    rc(OFS_EN_SET, 32'h0000_FFFF);
    // Legacy generation filters from element 0; the self filter from element 9, which may not generate
    wr(OFS_LEG_SGI_GEN, 32'h0004_0003);
    pend(5'h02, 32'h0000_0008);
    pend(5'h00, 32'h0);
    wr(OFS_LEG_SGI_GEN, 32'h0100_0005);
    pend(5'h09, 32'h0000_0020);
    pend(5'h00, 32'h0);
    wr(OFS_CONTEXT, 32'h9);
    wr(OFS_LEG_SGI_GEN, 32'h0200_0006);
    pend(5'h09, 32'h0000_0020);
    pend(5'h00, 32'h0);
    wr(OFS_LEG_SGI_GEN, 32'h03FF_0007);
    pend(5'h01, 32'h0000_0020);
    pend(5'h00, 32'h0);
    // Group 1 behind a disabled Group 0 interrupt of higher priority
    wr(OFS_DIST_CTRL, 32'h2);
    wr(OFS_SGI_GROUP, 32'h0000_0010);
    wr(OFS_REDIST_SET, 32'h0000_0012);
    rc(OFS_PHYS_AHPP, 32'h4);
    rc(OFS_PHYS_HPP, {22'h0, ID_LEG_G1});
    rc(OFS_PHYS_AACK, 32'h4);
    rc(OFS_PHYS_ACK, {22'h0, ID_NONE});
    wr(OFS_EOI, 32'h4);
    wr(OFS_TOP_CTRL, 32'h1);
    wr(OFS_DIST_CTRL, 32'h3);
    rc(OFS_G0_ACK, {22'h0, ID_RM_G0});
    wr(OFS_TOP_CTRL, 32'h0);
    // Modifier, end of interrupt, virtual view, non-secure generation
    wr(OFS_SGI_GRPMOD, 32'h2);
    rc(OFS_PHYS_HPP, 32'h1);
    rc(OFS_PHYS_ACK, 32'h1);
    wr(OFS_REDIST_SET, 32'h2);
    rc(OFS_PHYS_HPP, {22'h0, ID_NONE});
    wr(OFS_EOI, 32'h1);
    rc(OFS_PHYS_HPP, 32'h1);
    wr(OFS_REDIST_CLR, 32'h2);
    wr(OFS_REDIST_SET, 32'h10);
    wr(OFS_CONTEXT, 32'h10);
    rc(OFS_VIRT_HPP, {22'h0, ID_LEG_G1});
    wr(OFS_VIRT_CTRL, 32'h1);
    rc(OFS_VIRT_HPP, 32'h4);
    wr(OFS_CONTEXT, 32'h11);
    rc(OFS_VIRT_HPP, 32'h5);
    wr(OFS_LEG_SGI_GEN, 32'h0200_0003);
    pend(5'h01, 32'h0000_0020);
    // Affinity routing in both states
    wr(OFS_DIST_CTRL, 32'h30);
    wr(OFS_LEG_SGI_GEN, 32'h0002_0009);
    rc(OFS_LEG_SGI_GEN, 32'h0);
    wr(OFS_PEND_SRC_SET, 32'h0000_FFFF);
    rc(OFS_PEND_SRC_SET, 32'h0);
    wr(OFS_IRQ_TARGETS, 32'h0000_00FF);
    rc(OFS_IRQ_TARGETS, 32'h0);
    pend(5'h01, 32'h0000_0020);
    // Asymmetric setup, then a single security state
    wr(OFS_DIST_CTRL, 32'h20);
    wr(OFS_TOP_CTRL, 32'hC);
    rc(OFS_CFG_STATUS, {30'h0, CFG_ASYM});
    wr(OFS_CONTEXT, 32'h10);
    wr(OFS_SYS_SGI_GEN, 32'h0200_0020);
    wr(OFS_SYS_SGI_GEN, 32'h0220_0020);
    pend(5'h15, 32'h0000_0020);
    wr(OFS_DIST_CTRL, 32'h60);
    wr(OFS_CONTEXT, 32'h10);
    wr(OFS_SYS_SGI_GEN, 32'h0A00_0008);
    wr(OFS_SYS_SGI_GEN, 32'h0B20_0008);
    pend(5'h13, 32'h0000_0C20);
    test_done;
  end
endmodule // lic_compat_bench
`default_nettype wire
